//--- bbx_params.svh
// Purpose: named constants for the bit-operation and branch executor
// Assumes: included by bare name, definitions only
// Notes: opcodes, operand fields, cycle budgets, reset values
`ifndef BBX_PARAMS_SVH
`define BBX_PARAMS_SVH
// ----------------------------------------
// Fixed opcodes
// ----------------------------------------
`define BBX_OP_CARRY_AND 8'h8B
`define BBX_OP_CARRY_XOR 8'hAB
`define BBX_OP_CARRY_IOR 8'h6B
`define BBX_OP_LOAD_CARRY 8'hCB
`define BBX_OP_TEST_DP 8'h0C
`define BBX_OP_TEST_ABS 8'h1C
`define BBX_OP_CLEAR_ACC_BIT 8'h2B
`define BBX_OP_FORCE_ACC_BIT 8'h0B
`define BBX_OP_CARRY_CLEAR 8'h20
`define BBX_OP_CARRY_FORCE 8'hA0
`define BBX_OP_G_FLAG_CLEAR 8'h40
`define BBX_OP_G_FLAG_FORCE 8'hC0
`define BBX_OP_OVERFLOW_CLEAR 8'h80
`define BBX_OP_INVERT_MEM_BIT 8'h4B
`define BBX_OP_STORE_CARRY_BIT 8'hEB
`define BBX_OP_TEST_CLEAR_MASK 8'h5C
`define BBX_OP_TEST_FORCE_MASK 8'h3C
`define BBX_OP_BRANCH_CARRY_ZERO 8'h50
`define BBX_OP_BRANCH_CARRY_ONE 8'hD0
`define BBX_OP_BRANCH_EQUAL 8'hF0
`define BBX_OP_BRANCH_UNEQUAL 8'h70
`define BBX_OP_BRANCH_NEGATIVE 8'h90
`define BBX_OP_BRANCH_POSITIVE 8'h10
`define BBX_OP_JUMP_REL_ALWAYS 8'h2F
// ----------------------------------------
// Opcode patterns and operand fields
// ----------------------------------------
`define BBX_PAT_MEM_BIT 4'h1
`define BBX_PAT_BR_ACC 4'h2
`define BBX_PAT_BR_DP 4'h3
`define BBX_PAT_LO_HI 3
`define BBX_PAT_CLR_POS 4
`define BBX_PAT_BIT_HI 7
`define BBX_PAT_BIT_LO 5
`define BBX_MB_BIT_HI 7
`define BBX_MB_BIT_LO 5
`define BBX_MB_INV_POS 4
`define BBX_MB_ADDR_HI 3
`define BBX_ACC_BIT_HI 2
`define BBX_SIGN_POS 7
`define BBX_OVF_POS 6
`define BBX_DP_PAGE_HI 7'h00
`define BBX_MB_PAGE_HI 4'h0
// ----------------------------------------
// Lengths, cycle budgets, reset values
// ----------------------------------------
`define BBX_LEN1 2'h1
`define BBX_LEN2 2'h2
`define BBX_LEN3 2'h3
`define BBX_CYC1 4'h1
`define BBX_CYC2 4'h2
`define BBX_CYC4 4'h4
`define BBX_CYC5 4'h5
`define BBX_CYC6 4'h6
`define BBX_CYC_TAKEN 4'h2
`define BBX_RST_PC 16'h0000
`define BBX_RST_ACC 8'h00
`endif

//--- bbx_pkg.sv
// Purpose: types shared by the bit-operation and branch executor
// Assumes: nothing imported, always used as bbx_pkg::name
// Notes: instruction classes, address modes, sequencer states
package bbx_pkg;
	typedef enum logic [4:0] {
		CLS_CARRY_AND_MEMBIT, CLS_CARRY_XOR_MEMBIT, CLS_CARRY_IOR_MEMBIT, CLS_LOAD_CARRY_FROM_BIT,
		CLS_BIT_TEST, CLS_FORCE_MEM_BIT, CLS_CLEAR_MEM_BIT, CLS_FORCE_ACC_BIT, CLS_CLEAR_ACC_BIT,
		CLS_CARRY_CLEAR, CLS_CARRY_FORCE, CLS_G_FLAG_CLEAR, CLS_G_FLAG_FORCE, CLS_OVERFLOW_CLEAR,
		CLS_INVERT_MEM_BIT, CLS_STORE_CARRY_BIT, CLS_TEST_CLEAR_MASK, CLS_TEST_FORCE_MASK,
		CLS_BRANCH_BIT_ZERO, CLS_BRANCH_BIT_ONE, CLS_BRANCH_CARRY_ZERO, CLS_BRANCH_CARRY_ONE,
		CLS_BRANCH_EQUAL, CLS_BRANCH_UNEQUAL, CLS_BRANCH_NEGATIVE, CLS_BRANCH_POSITIVE,
		CLS_JUMP_RELATIVE_ALWAYS, CLS_UNKNOWN
	} bbx_cls_t;
	typedef enum logic [1:0] {AM_NONE, AM_DP, AM_MEMBIT, AM_ABS} bbx_amode_t;
	typedef enum logic [2:0] {S_OP, S_B2, S_B3, S_RD, S_WR, S_PAD} bbx_state_t;
endpackage

//--- bbx_decode.sv
// Purpose: opcode to class, length, cycle budget and operand access
// Assumes: opcode valid in the cycle it is presented
// Notes: pure combinational table
`timescale 1ns/100ps
`include "bbx_params.svh"
module bbx_decode (
	// Opcode in
	input wire logic [7:0] opcode,
	// Decoded attributes
	output bbx_pkg::bbx_cls_t cls,
	output logic [1:0] nbytes,
	output logic [3:0] budget,
	output logic has_rd,
	output logic has_wr,
	output bbx_pkg::bbx_amode_t amode
);
	logic [14:0] row;

	function automatic logic [14:0] ent(bbx_pkg::bbx_cls_t c, logic [1:0] nb, logic [3:0] bud,
		logic rd, logic wr, bbx_pkg::bbx_amode_t am);
		return {c, nb, bud, rd, wr, am};
	endfunction

	// ----------------------------------------
	// Table
	// ----------------------------------------
	always_comb begin
		case (opcode)
			`BBX_OP_CARRY_AND: row = ent(bbx_pkg::CLS_CARRY_AND_MEMBIT, `BBX_LEN3, `BBX_CYC4, 1'b1, 1'b0,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_CARRY_XOR: row = ent(bbx_pkg::CLS_CARRY_XOR_MEMBIT, `BBX_LEN3, `BBX_CYC5, 1'b1, 1'b0,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_CARRY_IOR: row = ent(bbx_pkg::CLS_CARRY_IOR_MEMBIT, `BBX_LEN3, `BBX_CYC5, 1'b1, 1'b0,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_LOAD_CARRY: row = ent(bbx_pkg::CLS_LOAD_CARRY_FROM_BIT, `BBX_LEN3, `BBX_CYC4, 1'b1, 1'b0,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_TEST_DP: row = ent(bbx_pkg::CLS_BIT_TEST, `BBX_LEN2, `BBX_CYC4, 1'b1, 1'b0,
				bbx_pkg::AM_DP);
			`BBX_OP_TEST_ABS: row = ent(bbx_pkg::CLS_BIT_TEST, `BBX_LEN3, `BBX_CYC5, 1'b1, 1'b0,
				bbx_pkg::AM_ABS);
			`BBX_OP_CLEAR_ACC_BIT: row = ent(bbx_pkg::CLS_CLEAR_ACC_BIT, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_FORCE_ACC_BIT: row = ent(bbx_pkg::CLS_FORCE_ACC_BIT, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_CARRY_CLEAR: row = ent(bbx_pkg::CLS_CARRY_CLEAR, `BBX_LEN1, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_CARRY_FORCE: row = ent(bbx_pkg::CLS_CARRY_FORCE, `BBX_LEN1, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_G_FLAG_CLEAR: row = ent(bbx_pkg::CLS_G_FLAG_CLEAR, `BBX_LEN1, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_G_FLAG_FORCE: row = ent(bbx_pkg::CLS_G_FLAG_FORCE, `BBX_LEN1, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_OVERFLOW_CLEAR: row = ent(bbx_pkg::CLS_OVERFLOW_CLEAR, `BBX_LEN1, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_INVERT_MEM_BIT: row = ent(bbx_pkg::CLS_INVERT_MEM_BIT, `BBX_LEN3, `BBX_CYC5, 1'b1, 1'b1,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_STORE_CARRY_BIT: row = ent(bbx_pkg::CLS_STORE_CARRY_BIT, `BBX_LEN3, `BBX_CYC6, 1'b1, 1'b1,
				bbx_pkg::AM_MEMBIT);
			`BBX_OP_TEST_CLEAR_MASK: row = ent(bbx_pkg::CLS_TEST_CLEAR_MASK, `BBX_LEN3, `BBX_CYC6, 1'b1, 1'b1,
				bbx_pkg::AM_ABS);
			`BBX_OP_TEST_FORCE_MASK: row = ent(bbx_pkg::CLS_TEST_FORCE_MASK, `BBX_LEN3, `BBX_CYC6, 1'b1, 1'b1,
				bbx_pkg::AM_ABS);
			`BBX_OP_BRANCH_CARRY_ZERO: row = ent(bbx_pkg::CLS_BRANCH_CARRY_ZERO, `BBX_LEN2, `BBX_CYC2, 1'b0,
				1'b0, bbx_pkg::AM_NONE);
			`BBX_OP_BRANCH_CARRY_ONE: row = ent(bbx_pkg::CLS_BRANCH_CARRY_ONE, `BBX_LEN2, `BBX_CYC2, 1'b0,
				1'b0, bbx_pkg::AM_NONE);
			`BBX_OP_BRANCH_EQUAL: row = ent(bbx_pkg::CLS_BRANCH_EQUAL, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_BRANCH_UNEQUAL: row = ent(bbx_pkg::CLS_BRANCH_UNEQUAL, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_BRANCH_NEGATIVE: row = ent(bbx_pkg::CLS_BRANCH_NEGATIVE, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_BRANCH_POSITIVE: row = ent(bbx_pkg::CLS_BRANCH_POSITIVE, `BBX_LEN2, `BBX_CYC2, 1'b0, 1'b0,
				bbx_pkg::AM_NONE);
			`BBX_OP_JUMP_REL_ALWAYS: row = ent(bbx_pkg::CLS_JUMP_RELATIVE_ALWAYS, `BBX_LEN2, `BBX_CYC2, 1'b0,
				1'b0, bbx_pkg::AM_NONE);
			default: begin
				// Bit number rides in the high nibble, odd nibble means clear or branch-on-zero
				case (opcode[`BBX_PAT_LO_HI:0])
					`BBX_PAT_MEM_BIT: row = ent(opcode[`BBX_PAT_CLR_POS] ? bbx_pkg::CLS_CLEAR_MEM_BIT :
						bbx_pkg::CLS_FORCE_MEM_BIT, `BBX_LEN2, `BBX_CYC4, 1'b1, 1'b1, bbx_pkg::AM_DP);
					`BBX_PAT_BR_ACC: row = ent(opcode[`BBX_PAT_CLR_POS] ? bbx_pkg::CLS_BRANCH_BIT_ZERO :
						bbx_pkg::CLS_BRANCH_BIT_ONE, `BBX_LEN2, `BBX_CYC4, 1'b0, 1'b0, bbx_pkg::AM_NONE);
					`BBX_PAT_BR_DP: row = ent(opcode[`BBX_PAT_CLR_POS] ? bbx_pkg::CLS_BRANCH_BIT_ZERO :
						bbx_pkg::CLS_BRANCH_BIT_ONE, `BBX_LEN3, `BBX_CYC5, 1'b1, 1'b0, bbx_pkg::AM_DP);
					default: row = ent(bbx_pkg::CLS_UNKNOWN, `BBX_LEN1, `BBX_CYC1, 1'b0, 1'b0, bbx_pkg::AM_NONE);
				endcase
			end
		endcase
	end

	assign cls = bbx_pkg::bbx_cls_t'(row[14:10]);
	assign nbytes = row[9:8];
	assign budget = row[7:4];
	assign has_rd = row[3];
	assign has_wr = row[2];
	assign amode = bbx_pkg::bbx_amode_t'(row[1:0]);
endmodule // bbx_decode

//--- bbx_bitalu.sv
// Purpose: bit, carry, test and branch-condition arithmetic
// Assumes: operand is the memory byte, or the accumulator for accumulator forms
// Notes: combinational only
`timescale 1ns/100ps
`include "bbx_params.svh"
module bbx_bitalu (
	// Operands
	input wire bbx_pkg::bbx_cls_t cls,
	input wire logic [7:0] operand,
	input wire logic [7:0] acc,
	input wire logic [2:0] bitsel,
	input wire logic inv,
	// Flags in
	input wire logic flag_c,
	input wire logic flag_z,
	input wire logic flag_n,
	// Results
	output logic next_c,
	output logic [7:0] new_byte,
	output logic [7:0] new_acc,
	output logic test_n,
	output logic test_z,
	output logic test_v,
	output logic cond
);
	wire [7:0] mask = 8'h01 << bitsel;
	wire sel_bit = operand[bitsel];
	wire mb = sel_bit ^ inv;
	wire [7:0] diff = acc - operand;
	wire is_test = cls == bbx_pkg::CLS_BIT_TEST;

	// ----------------------------------------
	// Carry and byte results
	// ----------------------------------------
	always_comb begin
		case (cls)
			bbx_pkg::CLS_CARRY_AND_MEMBIT: next_c = flag_c & mb;
			bbx_pkg::CLS_CARRY_XOR_MEMBIT: next_c = flag_c ^ mb;
			bbx_pkg::CLS_CARRY_IOR_MEMBIT: next_c = flag_c | mb;
			bbx_pkg::CLS_LOAD_CARRY_FROM_BIT: next_c = mb;
			bbx_pkg::CLS_CARRY_FORCE: next_c = 1'b1;
			default: next_c = 1'b0;
		endcase
		case (cls)
			bbx_pkg::CLS_FORCE_MEM_BIT: new_byte = operand | mask;
			bbx_pkg::CLS_CLEAR_MEM_BIT: new_byte = operand & ~mask;
			bbx_pkg::CLS_INVERT_MEM_BIT: new_byte = operand ^ mask;
			bbx_pkg::CLS_STORE_CARRY_BIT: new_byte = flag_c ? (operand | mask) : (operand & ~mask);
			bbx_pkg::CLS_TEST_CLEAR_MASK: new_byte = operand & ~acc;
			bbx_pkg::CLS_TEST_FORCE_MASK: new_byte = operand | acc;
			default: new_byte = operand;
		endcase
		case (cls)
			bbx_pkg::CLS_BRANCH_BIT_ZERO: cond = ~sel_bit;
			bbx_pkg::CLS_BRANCH_BIT_ONE: cond = sel_bit;
			bbx_pkg::CLS_BRANCH_CARRY_ZERO: cond = ~flag_c;
			bbx_pkg::CLS_BRANCH_CARRY_ONE: cond = flag_c;
			bbx_pkg::CLS_BRANCH_EQUAL: cond = flag_z;
			bbx_pkg::CLS_BRANCH_UNEQUAL: cond = ~flag_z;
			bbx_pkg::CLS_BRANCH_NEGATIVE: cond = flag_n;
			bbx_pkg::CLS_BRANCH_POSITIVE: cond = ~flag_n;
			bbx_pkg::CLS_JUMP_RELATIVE_ALWAYS: cond = 1'b1;
			default: cond = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Accumulator and test flags
	// ----------------------------------------
	assign new_acc = (cls == bbx_pkg::CLS_FORCE_ACC_BIT) ? (acc | mask) : (acc & ~mask);
	assign test_z = is_test ? ((acc & operand) == 8'h00) : (diff == 8'h00);
	assign test_n = is_test ? operand[`BBX_SIGN_POS] : diff[`BBX_SIGN_POS];
	assign test_v = operand[`BBX_OVF_POS];
endmodule // bbx_bitalu

//--- bbx_core.sv
// Purpose: executes the bit-manipulation and relative-branch instruction groups
// Assumes: memory answers reads combinationally in the cycle the address is shown
// Notes: each instruction occupies exactly its budgeted number of cycles, a taken branch two cycles more
`timescale 1ns/100ps
`include "bbx_params.svh"
module bbx_core #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Execution control
	input wire logic run,
	output logic instr_done,
	output logic bad_opcode,
	// Memory port, combinational read
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// Architectural state
	output logic [15:0] pc,
	output logic [7:0] acc,
	output logic flag_n,
	output logic flag_v,
	output logic flag_g,
	output logic flag_z,
	output logic flag_c
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (CNT_W < 4) begin : g_bad_cnt_w
		$error("CNT_W too narrow for the longest cycle budget");
	end

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bbx_pkg::bbx_state_t state;
	bbx_pkg::bbx_state_t next_state;
	bbx_pkg::bbx_state_t adv_st;
	bbx_pkg::bbx_cls_t d_cls;
	bbx_pkg::bbx_amode_t d_am;
	logic [1:0] d_nb;
	logic [3:0] d_bud;
	logic d_rd;
	logic d_wr;
	logic [7:0] op_code;
	logic [7:0] op_lo;
	logic [7:0] op_hi;
	logic [7:0] mem_hold;
	logic [CNT_W-1:0] cnt;
	logic [3:0] budget;
	logic adv;
	logic alu_c;
	logic alu_n;
	logic alu_z;
	logic alu_v;
	logic alu_cond;
	logic [7:0] alu_byte;
	logic [7:0] alu_acc;

	function automatic logic [15:0] pc_add(logic [15:0] base, logic [7:0] rel);
		return base + {{8{rel[7]}}, rel};
	endfunction

	// ----------------------------------------
	// Decode and arithmetic
	// ----------------------------------------
	wire in_op = state == bbx_pkg::S_OP;
	wire in_rd = state == bbx_pkg::S_RD;
	wire in_wr = state == bbx_pkg::S_WR;
	wire [7:0] dec_in = in_op ? mem_rdata : op_code;

	bbx_decode u_decode (
		.opcode(dec_in),
		.cls(d_cls),
		.nbytes(d_nb),
		.budget(d_bud),
		.has_rd(d_rd),
		.has_wr(d_wr),
		.amode(d_am)
	);

	wire is_membit = d_am == bbx_pkg::AM_MEMBIT;
	wire pat_bit = d_cls == bbx_pkg::CLS_FORCE_MEM_BIT || d_cls == bbx_pkg::CLS_CLEAR_MEM_BIT ||
		d_cls == bbx_pkg::CLS_BRANCH_BIT_ZERO || d_cls == bbx_pkg::CLS_BRANCH_BIT_ONE;
	wire [2:0] bitsel = is_membit ? op_hi[`BBX_MB_BIT_HI:`BBX_MB_BIT_LO] :
		pat_bit ? dec_in[`BBX_PAT_BIT_HI:`BBX_PAT_BIT_LO] : mem_rdata[`BBX_ACC_BIT_HI:0];
	wire inv = is_membit & op_hi[`BBX_MB_INV_POS];
	wire [7:0] alu_src = (d_am == bbx_pkg::AM_NONE) ? acc : (in_rd ? mem_rdata : mem_hold);

	bbx_bitalu u_alu (
		.cls(d_cls),
		.operand(alu_src),
		.acc(acc),
		.bitsel(bitsel),
		.inv(inv),
		.flag_c(flag_c),
		.flag_z(flag_z),
		.flag_n(flag_n),
		.next_c(alu_c),
		.new_byte(alu_byte),
		.new_acc(alu_acc),
		.test_n(alu_n),
		.test_z(alu_z),
		.test_v(alu_v),
		.cond(alu_cond)
	);

	// ----------------------------------------
	// Operand address
	// ----------------------------------------
	// Direct page follows the G flag, so the flag selects page zero or one
	wire [15:0] addr_dp = {`BBX_DP_PAGE_HI, flag_g, op_lo};
	wire [15:0] addr_mb = {`BBX_MB_PAGE_HI, op_hi[`BBX_MB_ADDR_HI:0], op_lo};
	wire [15:0] addr_abs = {op_hi, op_lo};
	wire [15:0] eaddr = (d_am == bbx_pkg::AM_DP) ? addr_dp : is_membit ? addr_mb : addr_abs;

	// ----------------------------------------
	// Step sequencing
	// ----------------------------------------
	always_comb begin
		case (state)
			bbx_pkg::S_OP: begin
				adv = d_nb != `BBX_LEN1;
				adv_st = bbx_pkg::S_B2;
			end
			bbx_pkg::S_B2: begin
				adv = d_nb == `BBX_LEN3 || d_rd;
				adv_st = (d_nb == `BBX_LEN3) ? bbx_pkg::S_B3 : bbx_pkg::S_RD;
			end
			bbx_pkg::S_B3: begin
				adv = d_rd;
				adv_st = bbx_pkg::S_RD;
			end
			bbx_pkg::S_RD: begin
				adv = d_wr;
				adv_st = bbx_pkg::S_WR;
			end
			default: begin
				adv = 1'b0;
				adv_st = bbx_pkg::S_PAD;
			end
		endcase
	end

	wire fetch = (in_op & run) | state == bbx_pkg::S_B2 | state == bbx_pkg::S_B3;
	wire busy = !in_op || run;
	// Last natural step carries the instruction's effect
	wire last = busy && !adv && state != bbx_pkg::S_PAD;
	// Condition is judged only once every byte is in hand
	wire taken = last && alu_cond;
	wire [3:0] base_bud = in_op ? d_bud : budget;
	wire [3:0] eff_bud = taken ? base_bud + `BBX_CYC_TAKEN : base_bud;
	wire finish = busy && !adv && cnt == CNT_W'(eff_bud - `BBX_CYC1);
	wire [7:0] rel_now = (state == bbx_pkg::S_B2) ? mem_rdata : op_hi;
	wire [15:0] pc_inc = pc_add(pc, 8'h01);
	wire [15:0] pc_seq = fetch ? pc_inc : pc;

	assign next_state = !busy ? bbx_pkg::S_OP : adv ? adv_st : finish ? bbx_pkg::S_OP : bbx_pkg::S_PAD;

	// ----------------------------------------
	// Architectural next values
	// ----------------------------------------
	wire ex_carry = d_cls == bbx_pkg::CLS_CARRY_AND_MEMBIT || d_cls == bbx_pkg::CLS_CARRY_XOR_MEMBIT ||
		d_cls == bbx_pkg::CLS_CARRY_IOR_MEMBIT || d_cls == bbx_pkg::CLS_LOAD_CARRY_FROM_BIT ||
		d_cls == bbx_pkg::CLS_CARRY_CLEAR || d_cls == bbx_pkg::CLS_CARRY_FORCE;
	wire ex_test = d_cls == bbx_pkg::CLS_BIT_TEST;
	wire ex_mask = d_cls == bbx_pkg::CLS_TEST_CLEAR_MASK || d_cls == bbx_pkg::CLS_TEST_FORCE_MASK;
	wire ex_acc = d_cls == bbx_pkg::CLS_FORCE_ACC_BIT || d_cls == bbx_pkg::CLS_CLEAR_ACC_BIT;

	wire [15:0] next_pc = taken ? pc_add(pc_seq, rel_now) : pc_seq;
	wire next_c = (last && ex_carry) ? alu_c : flag_c;
	wire next_n = (last && (ex_test || ex_mask)) ? alu_n : flag_n;
	wire next_z = (last && (ex_test || ex_mask)) ? alu_z : flag_z;
	wire next_v = !last ? flag_v : ex_test ? alu_v :
		(d_cls == bbx_pkg::CLS_OVERFLOW_CLEAR) ? 1'b0 : flag_v;
	wire next_g = !last ? flag_g : (d_cls == bbx_pkg::CLS_G_FLAG_FORCE) ? 1'b1 :
		(d_cls == bbx_pkg::CLS_G_FLAG_CLEAR) ? 1'b0 : flag_g;
	wire [7:0] next_acc = (last && ex_acc) ? alu_acc : acc;
	wire [CNT_W-1:0] next_cnt = finish ? '0 : busy ? cnt + 1'b1 : cnt;
	wire [3:0] next_budget = (in_op || last) ? eff_bud : budget;

	// ----------------------------------------
	// Memory port
	// ----------------------------------------
	assign mem_addr = (in_rd || in_wr) ? eaddr : pc;
	assign mem_rd = fetch | in_rd;
	// Read-modify-write keeps other bits of the byte intact
	assign mem_wr = in_wr;
	assign instr_done = finish;
	assign bad_opcode = last && d_cls == bbx_pkg::CLS_UNKNOWN;

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= bbx_pkg::S_OP;
			cnt <= '0;
			budget <= `BBX_CYC1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			budget <= next_budget;
		end
	end

	// ----------------------------------------
	// Operand capture
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			op_code <= 8'h00;
			op_lo <= 8'h00;
			op_hi <= 8'h00;
			mem_hold <= 8'h00;
			mem_wdata <= 8'h00;
		end else begin
			if (in_op && run) begin
				op_code <= mem_rdata;
			end
			if (state == bbx_pkg::S_B2) begin
				op_lo <= mem_rdata;
			end
			if (state == bbx_pkg::S_B3) begin
				op_hi <= mem_rdata;
			end
			if (in_rd) begin
				mem_hold <= mem_rdata;
				mem_wdata <= alu_byte;
			end
		end
	end

	// ----------------------------------------
	// Architectural registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pc <= `BBX_RST_PC;
			acc <= `BBX_RST_ACC;
			flag_n <= 1'b0;
			flag_v <= 1'b0;
			flag_g <= 1'b0;
			flag_z <= 1'b0;
			flag_c <= 1'b0;
		end else begin
			pc <= next_pc;
			acc <= next_acc;
			flag_n <= next_n;
			flag_v <= next_v;
			flag_g <= next_g;
			flag_z <= next_z;
			flag_c <= next_c;
		end
	end
endmodule // bbx_core

//--- bbx_core_props.sv
// Purpose: port-level checks for bbx_core
// Assumes: bound to every bbx_core instance
// Notes: fetch cycles are rebuilt from instr_done and run
`timescale 1ns/100ps
module bbx_core_props #(
	parameter int CNT_W = 4
) (
	// Clock and control
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic instr_done,
	// Memory port
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_rdata,
	// State
	input wire logic [15:0] pc,
	input wire logic flag_n,
	input wire logic flag_v,
	input wire logic flag_g,
	input wire logic flag_z,
	input wire logic flag_c
);
	// ----------------------------------------
	// Fetch tracking
	// ----------------------------------------
	logic in_fetch;
	wire op_take = in_fetch & run;
	wire [7:0] op = mem_rdata;
	always_ff @(posedge sys_clk) in_fetch <= !resetn | instr_done | (in_fetch & !run);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	fetch_at_pc_a: assert property (op_take |-> mem_rd && mem_addr == pc) else $error("fetch not at pc");
	idle_no_read_a: assert property (in_fetch && !run |-> !mem_rd) else $error("read while stalled");
	carry_clear_a: assert property (op_take && op == 8'h20 |=> !flag_c && instr_done) else $error("carry clear");
	carry_force_a: assert property (op_take && op == 8'hA0 |=> flag_c && instr_done) else $error("carry set");
	g_clear_a: assert property (op_take && op == 8'h40 |=> !flag_g && instr_done) else $error("g clear");
	g_force_a: assert property (op_take && op == 8'hC0 |=> flag_g && instr_done) else $error("g set");
	v_clear_a: assert property (op_take && op == 8'h80 |=> !flag_v && instr_done) else $error("v clear");
	store_write_a: assert property (op_take && op == 8'hEB |-> ##4 mem_wr ##1 instr_done) else $error("store");
	invert_keep_a: assert property (op_take && op == 8'h4B |=>
		($stable({flag_n, flag_v, flag_z, flag_c}) && !instr_done)[*3] ##1 instr_done) else $error("invert");
	jump_len_a: assert property (op_take && op == 8'h2F |-> (!instr_done)[*3] ##1 instr_done) else $error("jump");
	write_once_a: assert property (mem_wr |=> !mem_wr) else $error("double write");
endmodule // bbx_core_props
bind bbx_core bbx_core_props #(.CNT_W(CNT_W)) i_props (.sys_clk(sys_clk), .resetn(resetn), .run(run),
	.instr_done(instr_done), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
	.pc(pc), .flag_n(flag_n), .flag_v(flag_v), .flag_g(flag_g), .flag_z(flag_z), .flag_c(flag_c));

//--- test_bit_ops_and_branch_exec.sv
// Purpose: runs two programs through bbx_core, with a reset between, and checks state and timing
// Assumes: memory answers combinationally, writes land on the rising edge
// Notes: each step starts mid opcode cycle and counts cycles to instr_done
`timescale 1ns/100ps
module test_bit_ops_and_branch_exec;
	logic sys_clk = 0, resetn = 0, run = 0;
	logic instr_done, bad_opcode, mem_rd, mem_wr, flag_n, flag_v, flag_g, flag_z, flag_c;
	logic [15:0] mem_addr, pc;
	logic [7:0] mem_wdata, mem_rdata, acc;
	logic [7:0] mem [0:65535];
	logic [7:0] prog [0:35] = '{8'hA0, 8'h8B, 8'h20, 8'h21, 8'h6B, 8'h20, 8'h31, 8'hAB, 8'h20, 8'h01, 8'hCB,
		8'h20, 8'h31, 8'hEB, 8'h20, 8'hE1, 8'h4B, 8'h20, 8'h01, 8'h0B, 8'h03, 8'h3C, 8'h20, 8'h01, 8'h50,
		8'h05, 8'hD0, 8'h02, 8'hFF, 8'hFF, 8'hC0, 8'h40, 8'h80, 8'h20, 8'h2F, 8'hF0};
	// Skipped bytes are unknown opcodes, so a wrong branch decision shows in the cycle count
	logic [7:0] prog2 [0:50] = '{8'h0C, 8'h40, 8'h80, 8'hE1, 8'h40, 8'h51, 8'h40, 8'h1C, 8'h40, 8'h00, 8'h0B,
		8'h00, 8'h0B, 8'h06, 8'h2B, 8'h06, 8'h5C, 8'h40, 8'h00, 8'hF0, 8'h01, 8'h70, 8'h01, 8'hFF, 8'h90,
		8'h01, 8'h10, 8'h01, 8'hFF, 8'h02, 8'h01, 8'hFF, 8'h12, 8'h01, 8'hE3, 8'h40, 8'h01, 8'hFF, 8'hF3,
		8'h40, 8'h01, 8'hFF, 8'hCB, 8'h40, 8'hE0, 8'h8B, 8'h40, 8'hF0, 8'hAB, 8'h40, 8'h10};
	logic last_bad;
	int error_cnt = 0, total_checks = 0;
	assign mem_rdata = mem[mem_addr];
	always @(posedge sys_clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	bbx_core #(.CNT_W(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .run(run), .instr_done(instr_done),
		.bad_opcode(bad_opcode), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .pc(pc), .acc(acc), .flag_n(flag_n), .flag_v(flag_v), .flag_g(flag_g),
		.flag_z(flag_z), .flag_c(flag_c));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Bounded, so a stuck sequencer ends the run
	task step(input int b);
		int n;
		n = 1;
		while (instr_done !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		if (instr_done !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		last_bad = bad_opcode;
		chk(n, b);
		@(negedge sys_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task carry_ops;
		step(2);
		chk(flag_c, 1);
		step(4);
		chk(flag_c, 0);
		step(5);
		chk(flag_c, 1);
		step(5);
		chk(flag_c, 0);
		step(4);
		chk(flag_c, 1);
	endtask
	task mem_ops;
		step(6);
		chk(mem[16'h0120], 8'h85);
		step(5);
		chk(mem[16'h0120], 8'h84);
		step(2);
		chk(acc, 8'h08);
		step(6);
		chk(mem[16'h0120], 8'h8C);
		chk({flag_n, flag_z}, 2'h2);
	endtask
	task branch_ops;
		step(2);
		step(4);
		chk(pc, 16'h001E);
		step(2);
		chk(flag_g, 1);
		step(2);
		chk(flag_g, 0);
		step(2);
		chk(flag_v, 0);
		step(2);
		chk(flag_c, 0);
		step(4);
		run = 0;
		chk(pc, 16'h0014);
		repeat (2) @(negedge sys_clk);
		chk({mem_rd, pc}, 17'h00014);
	endtask
	// Second program is loaded while reset holds the core still
	task reset_mid;
		resetn = 0;
		for (int i = 0; i < 51; i++) mem[i] = prog2[i];
		mem[16'h0040] = 8'h45;
		repeat (2) @(negedge sys_clk);
		chk({pc, acc, flag_n, flag_v, flag_g, flag_z, flag_c}, 29'h0000000);
		resetn = 1;
		run = 1;
	endtask
	task mask_ops;
		step(4);
		chk({flag_n, flag_v, flag_z}, 3'h3);
		chk(last_bad, 0);
		step(2);
		chk(flag_v, 0);
		step(4);
		chk(mem[16'h0040], 8'hC5);
		step(4);
		chk(mem[16'h0040], 8'hC1);
		step(5);
		chk({flag_n, flag_v, flag_z}, 3'h7);
		step(2);
		step(2);
		step(2);
		chk(acc, 8'h01);
		step(6);
		chk(mem[16'h0040], 8'hC0);
		chk({flag_n, flag_z}, 2'h0);
	endtask
	task bit_branch_ops;
		step(2);
		step(4);
		step(2);
		step(4);
		step(6);
		step(4);
		step(7);
		step(5);
		step(1);
		chk(last_bad, 1);
		step(4);
		chk(flag_c, 1);
		step(4);
		chk(flag_c, 0);
		step(5);
		chk(flag_c, 1);
		run = 0;
		chk(pc, 16'h0033);
	endtask
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
		for (int i = 0; i < 36; i++) mem[i] = prog[i];
		mem[16'h0120] = 8'h05;
		repeat (5) @(negedge sys_clk);
		resetn = 1;
		run = 1;
		carry_ops();
		mem_ops();
		branch_ops();
		reset_mid();
		mask_ops();
		bit_branch_ops();
		stop_test();
	end
endmodule // test_bit_ops_and_branch_exec
